/* hw/dmc_mode_ctrl.sv */
// Mode and channel control of an eight channel load switch: pin synchronisers,
// fallback and sleep entry, serial register access, overcurrent latch-off.
// Assumes pins and supply monitors other than pwm_gen_in and restart_delay_sel_in are asynchronous to mclk_in, and an
// SCLK well below a quarter of the core clock rate.
`timescale 1ns/100ps

module dmc_mode_ctrl
    import dmc_pkg::*;
#(
    parameter int RESTART_CYCLES = RESTART_BASE_CYCLES
) (
    input  wire logic       mclk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       direct_input_a_in,
    input  wire logic       direct_input_b_in,
    input  wire logic       sleep_request_n_in,
    input  wire logic       vdd_uv_in,
    input  wire logic       vm_uv_in,
    input  wire logic [7:0] overcurrent_in,
    input  wire logic [1:0] pwm_gen_in,
    input  wire logic [1:0] restart_delay_sel_in,
    input  wire logic       spi_sclk_in,
    input  wire logic       spi_cs_n_in,
    input  wire logic       spi_sdi_in,
    output logic            spi_sdo_out,
    output logic            spi_sdo_oe_out,
    output logic [7:0]      channel_drive_out,
    output logic [7:0]      open_load_probe_current_out,
    output logic [1:0]      input_level_monitor_out,
    output logic            uv_detect_en_out,
    output dmc_mode_type    mode_out
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    dmc_state_type state;
    dmc_state_type next_state;

    // Working values of the combinational process
    dmc_pins_type       pins;
    logic               regs_clear;
    logic               spi_ok;
    logic               sclk_rise;
    logic               sclk_fall;
    logic               commit;
    logic [15:0]        frame;
    logic [2:0]         addr;
    logic [7:0]         wdata;
    logic [15:0]        resp;
    logic [7:0]         resp_data;
    logic [7:0]         raw_drive;
    logic [7:0]         oc_clear;
    logic [7:0]         fb_pins;
    logic [7:0]         pending;
    logic [RETRY_W-1:0] retry_limit;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_state = state;
        pins       = state.sync2;
        oc_clear   = 8'h00;
        commit     = 1'b0;
        frame      = state.shreg;
        addr       = frame[CMD_ADDR_HI:CMD_ADDR_LO];
        wdata      = frame[CMD_DATA_HI:0];

        // Two-stage synchronisers; logic reads only the second stage
        next_state.sync1 = '{
            overcurrent:     overcurrent_in,
            vdd_uv:          vdd_uv_in,
            vm_uv:           vm_uv_in,
            sclk:            spi_sclk_in,
            cs_n:            spi_cs_n_in,
            sdi:             spi_sdi_in,
            sleep_request_n: sleep_request_n_in,
            direct_input_b:  direct_input_b_in,
            direct_input_a:  direct_input_a_in
        };
        next_state.sync2     = state.sync1;
        next_state.sclk_prev = pins.sclk;

        // Mode follows the pins; host keeps the sleep pin stable long enough
        if (pins.sleep_request_n) begin
            next_state.mode = MODE_NORMAL;
        end else if (pins.direct_input_a || pins.direct_input_b) begin
            next_state.mode = MODE_FALLBACK;
        end else begin
            next_state.mode = MODE_SLEEP;
        end

        // Registers held at default while sleep pin low or digital supply low
        regs_clear = !pins.sleep_request_n || pins.vdd_uv;

        // Serial port alive only with digital supply and outside sleep
        spi_ok = !pins.vdd_uv
               && !(!pins.sleep_request_n
                    && !pins.direct_input_a
                    && !pins.direct_input_b);
        sclk_rise = pins.sclk && !state.sclk_prev;
        sclk_fall = !pins.sclk && state.sclk_prev;

        // Answer word for the next frame: echo of last committed address, read or write, plus data
        unique case (state.rd_addr)
            ADDR_EN:       resp_data = state.regs.en;
            ADDR_MAP_A:    resp_data = state.regs.input_a_channel_map;
            ADDR_MAP_B:    resp_data = state.regs.input_b_channel_map;
            ADDR_PWM0_MAP: resp_data = state.regs.pwm0_map;
            ADDR_PWM1_MAP: resp_data = state.regs.pwm1_map;
            ADDR_OL_EN:    resp_data = state.regs.ol_en;
            ADDR_OC_CLR:   resp_data = state.oc_latch;
            ADDR_STATUS:   resp_data = {state.mode, pins.vm_uv, pins.vdd_uv,
                                        2'b00, pins.direct_input_b,
                                        pins.direct_input_a};
        endcase
        resp = {1'b0, state.rd_addr, 4'h0, resp_data};

        ////////////////////////////////////////////////////////////////////////
        // Serial shift engine, sampled on falling SCLK, driven on rising SCLK
        if (!spi_ok || pins.cs_n) begin
            // Whole multiple of 8 bits, 16 to 248: last 16 bits are ours
            commit = state.active && spi_ok
                   && (state.bit_cnt >= 8'(FRAME_BITS))
                   && (state.bit_cnt[2:0] == 3'(CHAIN_BITS % 8));
            next_state.active  = 1'b0;
            next_state.sdo_oe  = 1'b0;
            next_state.sdo     = 1'b0;
            next_state.bit_cnt = 8'h00;
        end else if (!state.active) begin
            next_state.active  = 1'b1;
            next_state.shreg   = resp;
            next_state.sdo     = resp[FRAME_BITS-1];
            next_state.sdo_oe  = 1'b1;
            next_state.bit_cnt = 8'h00;
        end else begin
            if (sclk_fall) begin
                // Bits beyond 16 pass through to the next device in the chain
                next_state.shreg = {state.shreg[FRAME_BITS-2:0], pins.sdi};
                if (state.bit_cnt != 8'hff) begin
                    next_state.bit_cnt = state.bit_cnt + 8'h01;
                end
            end
            if (sclk_rise) begin
                next_state.sdo = state.shreg[FRAME_BITS-1];
            end
        end

        // Frame commit: writes and read address capture
        if (commit) begin
            next_state.rd_addr = addr;
            if (frame[CMD_WR_BIT]) begin
                unique case (addr)
                    ADDR_EN:       next_state.regs.en = wdata;
                    ADDR_MAP_A:    next_state.regs.input_a_channel_map = wdata;
                    ADDR_MAP_B:    next_state.regs.input_b_channel_map = wdata;
                    ADDR_PWM0_MAP: next_state.regs.pwm0_map = wdata;
                    ADDR_PWM1_MAP: next_state.regs.pwm1_map = wdata;
                    ADDR_OL_EN:    next_state.regs.ol_en = wdata;
                    ADDR_OC_CLR:   oc_clear = wdata;
                    ADDR_STATUS:   oc_clear = 8'h00;
                endcase
            end
        end
        if (regs_clear) begin
            next_state.regs = REGS_RST;
        end

        ////////////////////////////////////////////////////////////////////////
        // Fallback restart timer, shared by the two pin-driven channels
        fb_pins = {4'h0, pins.direct_input_b, pins.direct_input_a, 2'b00};
        pending = state.oc_latch & fb_pins;
        retry_limit = RETRY_W'(RESTART_CYCLES) << restart_delay_sel_in;
        if (state.mode == MODE_FALLBACK && pending != 8'h00) begin
            if (state.retry_cnt >= retry_limit - RETRY_W'(1)) begin
                oc_clear = oc_clear | pending;
                next_state.retry_cnt = '0;
            end else begin
                next_state.retry_cnt = state.retry_cnt + RETRY_W'(1);
            end
        end else begin
            next_state.retry_cnt = '0;
        end

        // Overcurrent latch; a new event beats a clear in the same cycle
        next_state.oc_latch = (state.oc_latch & ~oc_clear)
                            | (pins.overcurrent & state.drive);

        ////////////////////////////////////////////////////////////////////////
        // Channel drive selection
        unique case (state.mode)
            MODE_NORMAL: begin
                raw_drive = state.regs.en
                          | (pwm_gen_in[0] ? state.regs.pwm0_map : 8'h00)
                          | (pwm_gen_in[1] ? state.regs.pwm1_map : 8'h00)
                          | (pins.direct_input_a ?
                             state.regs.input_a_channel_map : 8'h00)
                          | (pins.direct_input_b ?
                             state.regs.input_b_channel_map : 8'h00);
            end
            MODE_FALLBACK: begin
                raw_drive = fb_pins & FB_CH_MASK;
            end
            MODE_SLEEP: begin
                raw_drive = 8'h00;
            end
            // Unused code 10: keep every stage off
            default: begin
                raw_drive = 8'h00;
            end
        endcase
        // Analog undervoltage gates all stages; drive returns by itself after
        next_state.drive = raw_drive & ~state.oc_latch
                         & {NUM_CH{!pins.vm_uv}};
        // Probe current only on channels that are off
        next_state.probe = state.regs.ol_en & ~state.drive;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= STATE_RST;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops; uv_detect_en_out is decoded from the registered mode
    assign spi_sdo_out                 = state.sdo;
    assign spi_sdo_oe_out              = state.sdo_oe;
    assign channel_drive_out           = state.drive;
    assign open_load_probe_current_out = state.probe;
    assign input_level_monitor_out     = {state.sync2.direct_input_b,
                                          state.sync2.direct_input_a};
    assign uv_detect_en_out            = (state.mode != MODE_SLEEP);
    assign mode_out                    = state.mode;

endmodule

/* hw/dmc_pkg.sv */
// Constants, field layouts and state types of the driver mode and input control block.
// Assumes one 20 MHz core clock; every other package-user imports dmc_pkg::*.
package dmc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_CH      = 8;
    localparam int FRAME_BITS  = 16;
    localparam int CHAIN_BITS  = 8;
    localparam int RETRY_W     = 24;

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame fields
    localparam int CMD_WR_BIT  = 15;
    localparam int CMD_ADDR_HI = 14;
    localparam int CMD_ADDR_LO = 12;
    localparam int CMD_DATA_HI = 7;

    // Register addresses
    localparam logic [2:0] ADDR_EN       = 3'h0;
    localparam logic [2:0] ADDR_MAP_A    = 3'h1;
    localparam logic [2:0] ADDR_MAP_B    = 3'h2;
    localparam logic [2:0] ADDR_PWM0_MAP = 3'h3;
    localparam logic [2:0] ADDR_PWM1_MAP = 3'h4;
    localparam logic [2:0] ADDR_OL_EN    = 3'h5;
    localparam logic [2:0] ADDR_OC_CLR   = 3'h6;
    localparam logic [2:0] ADDR_STATUS   = 3'h7;

    // Reset values and fallback channel mask
    localparam logic [7:0] EN_RST     = 8'h00;
    localparam logic [7:0] MAP_A_RST  = 8'h04;
    localparam logic [7:0] MAP_B_RST  = 8'h08;
    localparam logic [7:0] PWM_RST    = 8'h00;
    localparam logic [7:0] OL_EN_RST  = 8'h00;
    localparam logic [7:0] FB_CH_MASK = 8'h0c;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_HZ              = 20_000_000;
    localparam int RESTART_BASE_MS     = 10;
    localparam int RESTART_BASE_CYCLES = CLK_HZ / 1000 * RESTART_BASE_MS;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        MODE_NORMAL   = 2'b00,
        MODE_FALLBACK = 2'b01,
        MODE_SLEEP    = 2'b11
    } dmc_mode_type;

    typedef struct packed {
        logic [7:0] en;
        logic [7:0] input_a_channel_map;
        logic [7:0] input_b_channel_map;
        logic [7:0] pwm0_map;
        logic [7:0] pwm1_map;
        logic [7:0] ol_en;
    } dmc_regs_type;

    typedef struct packed {
        logic [7:0] overcurrent;
        logic       vdd_uv;
        logic       vm_uv;
        logic       sclk;
        logic       cs_n;
        logic       sdi;
        logic       sleep_request_n;
        logic       direct_input_b;
        logic       direct_input_a;
    } dmc_pins_type;

    typedef struct packed {
        dmc_pins_type       sync1;
        dmc_pins_type       sync2;
        logic               sclk_prev;
        dmc_mode_type       mode;
        dmc_regs_type       regs;
        logic [7:0]         oc_latch;
        logic [15:0]        shreg;
        logic [7:0]         bit_cnt;
        logic [2:0]         rd_addr;
        logic               active;
        logic               sdo;
        logic               sdo_oe;
        logic [7:0]         drive;
        logic [7:0]         probe;
        logic [RETRY_W-1:0] retry_cnt;
    } dmc_state_type;

    localparam dmc_regs_type REGS_RST = '{
        en:                  EN_RST,
        input_a_channel_map: MAP_A_RST,
        input_b_channel_map: MAP_B_RST,
        pwm0_map:            PWM_RST,
        pwm1_map:            PWM_RST,
        ol_en:               OL_EN_RST
    };

    localparam dmc_state_type STATE_RST = '{
        regs:    REGS_RST,
        mode:    MODE_SLEEP,
        default: '0
    };

endpackage

/* test/dmc_mode_chk.sv */
// Port-level assertions of the mode and input control block.
// Assumes dmc_pkg is compiled first and one clock domain on mclk_in.
`timescale 1ns/100ps

module dmc_mode_chk
    import dmc_pkg::*;
(
    input wire logic         mclk_in,
    input wire logic         sys_rst_in,
    input wire logic         direct_input_a_in,
    input wire logic         direct_input_b_in,
    input wire logic         sleep_request_n_in,
    input wire logic         vdd_uv_in,
    input wire logic         vm_uv_in,
    input wire logic         spi_cs_n_in,
    input wire logic         spi_sdo_oe_out,
    input wire logic [7:0]   channel_drive_out,
    input wire logic [7:0]   open_load_probe_current_out,
    input wire logic [1:0]   input_level_monitor_out,
    input wire logic         uv_detect_en_out,
    input wire dmc_mode_type mode_out
);
    ////////////////////////////////////////
    // Single domain, so clock and reset are given once
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    // Pin patterns held long enough to cross the synchronisers
    sequence s_sleep;
        (!sleep_request_n_in && !direct_input_a_in && !direct_input_b_in) [*4];
    endsequence
    sequence s_limp;
        (!sleep_request_n_in && (direct_input_a_in || direct_input_b_in)) [*4];
    endsequence
    sequence s_awake;
        sleep_request_n_in [*4];
    endsequence

    ////////////////////////////////////////
    property p_sleep;
        s_sleep |-> mode_out == MODE_SLEEP && !uv_detect_en_out;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep mode or detector state wrong");
    property p_sleep_sdo;
        s_sleep |=> !spi_sdo_oe_out;
    endproperty
    a_sleep_sdo: assert property (p_sleep_sdo)
        else $error("serial output driven in sleep");
    property p_limp;
        s_limp |-> mode_out == MODE_FALLBACK;
    endproperty
    a_limp: assert property (p_limp)
        else $error("fallback mode not entered");
    property p_awake;
        s_awake |-> mode_out == MODE_NORMAL && uv_detect_en_out;
    endproperty
    a_awake: assert property (p_awake)
        else $error("normal mode or detector state wrong");
    property p_fb_only;
        (mode_out == MODE_FALLBACK) [*2] |-> (channel_drive_out & ~FB_CH_MASK) == 8'h00;
    endproperty
    a_fb_only: assert property (p_fb_only)
        else $error("fallback drives a foreign channel");
    property p_fb_off;
        (mode_out == MODE_FALLBACK && !direct_input_a_in) [*5] |-> !channel_drive_out[2];
    endproperty
    a_fb_off: assert property (p_fb_off)
        else $error("fallback channel on with its pin low");
    property p_sleep_off;
        (mode_out == MODE_SLEEP) [*3] |-> channel_drive_out == 8'h00
            && open_load_probe_current_out == 8'h00;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("outputs active in sleep");
    property p_vm_uv;
        vm_uv_in [*5] |-> channel_drive_out == 8'h00;
    endproperty
    a_vm_uv: assert property (p_vm_uv)
        else $error("channel on during analog undervoltage");
    property p_vdd_uv;
        vdd_uv_in [*5] |-> !spi_sdo_oe_out;
    endproperty
    a_vdd_uv: assert property (p_vdd_uv)
        else $error("serial output driven without digital supply");
    property p_cs_idle;
        spi_cs_n_in [*5] |-> !spi_sdo_oe_out;
    endproperty
    a_cs_idle: assert property (p_cs_idle)
        else $error("serial output driven while deselected");
    property p_monitor;
        $stable({direct_input_b_in, direct_input_a_in}) [*4]
            |-> input_level_monitor_out == {direct_input_b_in, direct_input_a_in};
    endproperty
    a_monitor: assert property (p_monitor)
        else $error("input monitor does not follow pins");
endmodule

bind dmc_mode_ctrl dmc_mode_chk chk_u (.*);

/* test/dmc_host_model.sv */
// Host serial master: frames of n bits, msb first, 400 ns per bit.
// Assumes frames start on a falling mclk edge, so edges stay there.
`timescale 1ns/100ps

module dmc_host_model (
    input  wire logic spi_sdo_in,
    input  wire logic spi_sdo_oe_in,
    output logic      spi_sclk_out,
    output logic      spi_cs_n_out,
    output logic      spi_sdi_out
);
    logic oe_seen;

    // Idle bus: deselected, clock parked low
    initial begin
        spi_sclk_out = 1'h0;
        spi_cs_n_out = 1'h1;
        spi_sdi_out  = 1'h0;
        oe_seen      = 1'h0;
    end

    // Any enable inside a frame is remembered for blocked-access checks
    always @(posedge spi_sdo_oe_in) oe_seen = 1'h1;

    ////////////////////////////////////////
    // Data changes in the low phase; answer bit is read just before each fall,
    // since the device only moves its output a few core cycles after the rise
    task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h0;
        oe_seen = 1'h0;
        spi_cs_n_out = 1'h0;
        #400;
        for (int i = n - 1; i >= 0; i--) begin
            #100 spi_sdi_out = tx[i];
            #100 spi_sclk_out = 1'h1;
            #200 rx = {rx[30:0], spi_sdo_in};
            spi_sclk_out = 1'h0;
        end
        #200 spi_cs_n_out = 1'h1;
        // Released line must not keep showing stale data
        spi_sdi_out = ~spi_sdi_out;
        #400;
    endtask
endmodule

/* test/test_dmc_mode_ctrl.sv */
// Self-checking bench of the mode and input control block.
// Assumes dmc_pkg, the design, host model and checker are compiled first.
`timescale 1ns/100ps

module test_dmc_mode_ctrl
    import dmc_pkg::*;
;
    localparam int RC = 20;
    logic         mclk, rst, in_a, in_b, slp_n, vdd_uv, vm_uv;
    logic         sclk, cs_n, sdi, sdo, sdo_oe, uv_en;
    logic [7:0]   oc, drive, probe, d;
    logic [1:0]   pwm, sel, mon;
    logic [31:0]  rx;
    dmc_mode_type mode;
    int           num_errors = 0;
    int           tests_run = 0;
    int           n;

    // 20 MHz core clock
    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end

    dmc_mode_ctrl #(.RESTART_CYCLES(RC)) dut_u (
        .mclk_in(mclk), .sys_rst_in(rst), .direct_input_a_in(in_a),
        .direct_input_b_in(in_b), .sleep_request_n_in(slp_n), .vdd_uv_in(vdd_uv),
        .vm_uv_in(vm_uv), .overcurrent_in(oc), .pwm_gen_in(pwm),
        .restart_delay_sel_in(sel), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
        .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe),
        .channel_drive_out(drive), .open_load_probe_current_out(probe),
        .input_level_monitor_out(mon), .uv_detect_en_out(uv_en), .mode_out(mode));

    dmc_host_model host_u (.spi_sdo_in(sdo), .spi_sdo_oe_in(sdo_oe),
        .spi_sclk_out(sclk), .spi_cs_n_out(cs_n), .spi_sdi_out(sdi));

    ////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic send(input int k, input logic [31:0] tx);
        host_u.frame(k, tx, rx);
        cyc(2);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        send(16, {16'h0, 1'h1, a, 4'h0, v});
    endtask
    // Answer to a read comes back in the following frame
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        host_u.frame(16, {16'h0, 1'h0, a, 12'h0}, rx);
        host_u.frame(16, 32'h0, rx);
        v = rx[7:0];
    endtask
    // Pins move together and are held past the mode transition time
    task automatic pins(input logic s, input logic b, input logic a);
        @(negedge mclk);
        slp_n = s;
        in_b = b;
        in_a = a;
        cyc(8);
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog, far beyond the few hundred microseconds the tests need
    initial begin
        #1_000_000;
        num_errors++;
        conclude();
    end

    ////////////////////////////////////////
    initial begin
        {rst, slp_n, in_a, in_b, vdd_uv, vm_uv} = 6'h20;
        {oc, pwm, sel} = 12'h0;
        cyc(5);
        rst = 1'h0;
        cyc(6);
        chk("mode", MODE_SLEEP, mode);
        chk("uv detect enable", 16'h0, uv_en);
        send(16, 32'h0);
        chk("sdo enable", 16'h0, host_u.oe_seen);
        pins(1'h1, 1'h0, 1'h0);
        chk("mode", MODE_NORMAL, mode);
        chk("uv detect enable", 16'h1, uv_en);
        rd(ADDR_MAP_A, d);
        chk("map a", MAP_A_RST, d);
        pins(1'h1, 1'h1, 1'h1);
        chk("drive", 8'h0c, drive);
        chk("input monitor", 2'h3, mon);
        wr(ADDR_MAP_A, 8'h81);
        chk("drive", 8'h89, drive);
        pins(1'h1, 1'h0, 1'h0);
        wr(ADDR_EN, 8'h10);
        wr(ADDR_PWM0_MAP, 8'h20);
        wr(ADDR_PWM1_MAP, 8'h40);
        wr(ADDR_OL_EN, 8'hff);
        pwm = 2'h1;
        cyc(3);
        chk("drive", 8'h30, drive);
        pwm = 2'h2;
        cyc(3);
        chk("drive", 8'h50, drive);
        pwm = 2'h0;
        cyc(3);
        chk("probe current", 8'hef, probe);
        // Latched channel stays off until cleared by a write
        oc = 8'h10;
        cyc(4);
        oc = 8'h00;
        cyc(6);
        chk("drive", 8'h00, drive);
        rd(ADDR_OC_CLR, d);
        chk("latched", 8'h10, d);
        wr(ADDR_OC_CLR, 8'h10);
        chk("drive", 8'h10, drive);
        // Chained frames: 32 and 24 bits commit, 20 bits do not
        send(32, {16'habcd, 1'h1, ADDR_EN, 4'h0, 8'h33});
        chk("chained word", 16'habcd, rx[15:0]);
        chk("drive", 8'h33, drive);
        send(20, {16'h0, 1'h1, ADDR_EN, 4'h0, 8'h55});
        chk("drive", 8'h33, drive);
        send(24, {16'h0, 1'h1, ADDR_EN, 4'h0, 8'h44});
        chk("drive", 8'h44, drive);
        vm_uv = 1'h1;
        cyc(6);
        chk("drive", 8'h00, drive);
        vm_uv = 1'h0;
        cyc(6);
        chk("drive", 8'h44, drive);
        {vdd_uv, vm_uv} = 2'h3;
        cyc(6);
        chk("drive", 8'h00, drive);
        send(16, {16'h0, 1'h1, ADDR_EN, 4'h0, 8'h77});
        chk("sdo enable", 16'h0, host_u.oe_seen);
        {vdd_uv, vm_uv} = 2'h0;
        cyc(6);
        rd(ADDR_EN, d);
        chk("enable reg", EN_RST, d);
        wr(ADDR_EN, 8'h01);
        pins(1'h0, 1'h1, 1'h0);
        chk("mode", MODE_FALLBACK, mode);
        chk("drive", 8'h08, drive);
        pins(1'h0, 1'h1, 1'h1);
        chk("drive", 8'h0c, drive);
        chk("input monitor", 2'h3, mon);
        // Each restart delay setting, timed from the overcurrent event
        for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            oc = 8'h04;
            cyc(4);
            oc = 8'h00;
            cyc(4);
            n = 0;
            while (drive[2] !== 1'h1 && n < 2000) begin
                cyc(1);
                n++;
            end
            chk("restart span ok", 16'h1, 16'(n >= (RC << s) - 10 && n <= (RC << s) + 6));
        end
        pins(1'h1, 1'h0, 1'h0);
        rd(ADDR_EN, d);
        chk("enable reg", EN_RST, d);
        conclude();
    end
endmodule
